// File: hw/oaq_pkg.sv
// Package of the overcurrent alert qualifier: map, codes, state layout.
// Assumes a 10 MHz core clock and pre-decoded three-state pin codes.
package oaq_pkg;
	// Clock and window timing
	localparam int CLK_NS = 100;
	localparam int WIN_NS = 10000;
	localparam int WIN_CYC = WIN_NS / CLK_NS;
	localparam logic [6:0] WIN_LAST = 7'(WIN_CYC - 1);
	// Consecutive windows per response setting (10, 50, 100 us)
	localparam logic [3:0] QUAL_FAST = 4'h1;
	localparam logic [3:0] QUAL_MID = 4'h5;
	localparam logic [3:0] QUAL_SLOW = 4'ha;
	// Three-state pin codes from the level detector
	localparam logic [1:0] PIN_FLOAT = 2'h0;
	localparam logic [1:0] PIN_GND = 2'h1;
	localparam logic [1:0] PIN_SUPPLY = 2'h2;
	// Band width in mV
	localparam logic [3:0] BAND_FLOAT_MV = 4'h2;
	localparam logic [3:0] BAND_GND_MV = 4'h4;
	localparam logic [3:0] BAND_SUPPLY_MV = 4'h8;
	// Register byte offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_INT_STAT = 4'h8;
	localparam logic [3:0] REG_INT_MASK = 4'hc;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Event bits: 0 alert raised, 1 alert released
	localparam int EV_RAISE = 0;
	localparam int EV_FALL = 1;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ALERT = 2'b10
	} oaq_fsm_t;

	// Pins from outside the clock domain
	typedef struct packed {
		logic en;
		logic latch;
		logic over;
		logic [1:0] dly;
		logic [1:0] band_width_select;
	} oaq_pin_t;

	typedef struct packed {
		oaq_pin_t sm;
		oaq_pin_t ss;
		logic [6:0] win_q;
		logic [3:0] cnt_q;
		oaq_fsm_t fsm;
		logic [3:0] band_q;
		logic sw_en_q;
		logic [1:0] ist_q;
		logic [1:0] imsk_q;
		logic aw_got;
		logic [3:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} oaq_state_t;

	// Windows needed for a response setting
	function automatic logic [3:0] qual_need(input logic [1:0] code);
		if (code == PIN_GND) begin
			return QUAL_MID;
		end else if (code == PIN_SUPPLY) begin
			return QUAL_SLOW;
		end
		return QUAL_FAST;
	endfunction

	// Band width in mV for a band select code
	function automatic logic [3:0] band_mv(input logic [1:0] code);
		if (code == PIN_GND) begin
			return BAND_GND_MV;
		end else if (code == PIN_SUPPLY) begin
			return BAND_SUPPLY_MV;
		end
		return BAND_FLOAT_MV;
	endfunction
endpackage

// File: hw/oaq_top.sv
// Alert qualifier: window timer, consecutive counter, alert FSM, AXI4-Lite regs.
// Assumes pins arrive asynchronous; comparator bit is the window average result.
// How it works
// - window timer runs free, no control
// - compare only at each window end
// - window unaligned to the input
// - mid adds 40 us, long 90 us
// - band select decodes 2, 4, 8 mV
// - alert output is active low
// - hold select low transparent, high latched
// - transparent releases after one below window
// - latched alert stays low when input drops
// - clear only when input is below limit
// - response select decodes 10, 50, 100 us
// - one, five or ten consecutive windows qualify
// - a below window zeroes the counter
// - disable zeroes counter, restart on enable
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module oaq_top
	import oaq_pkg::*;
(
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RESET,
	// Device pins
	input wire oaq_pin_t PINS,
	output logic ALERT_N,
	output logic [3:0] BAND_WIDTH_SELECT,
	output logic IRQ,
	// AXI4-Lite write
	input wire logic [3:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// AXI4-Lite read
	input wire logic [3:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);
	oaq_state_t q;
	oaq_state_t d;
	logic tick;
	logic en;
	logic alert;
	logic hit;
	logic [3:0] req;
	logic [3:0] cnt_inc;
	logic [1:0] ev;
	logic [1:0] clr;

	// Handshakes and outputs
	assign AWREADY = !q.aw_got && !q.bvalid;
	assign WREADY = !q.w_got && !q.bvalid;
	assign ARREADY = !q.rvalid;
	assign BVALID = q.bvalid;
	assign BRESP = q.bresp;
	assign RVALID = q.rvalid;
	assign RDATA = q.rdata;
	assign RRESP = q.rresp;
	assign alert = (q.fsm == ST_ALERT);
	assign ALERT_N = !alert;
	assign BAND_WIDTH_SELECT = q.band_q;
	assign IRQ = |(q.ist_q & q.imsk_q);

	// Next state
	always_comb begin
		d = q;
		ev = 2'h0;
		clr = 2'h0;
		// Two-stage pin synchroniser
		d.sm = PINS;
		d.ss = q.sm;
		// Free-running window, never restarted by the input
		tick = (q.win_q == WIN_LAST);
		d.win_q = tick ? 7'h00 : q.win_q + 7'h01;
		en = q.ss.en && q.sw_en_q;
		req = qual_need(q.ss.dly);
		cnt_inc = q.cnt_q + 4'h1;
		hit = (cnt_inc >= req);
		d.band_q = band_mv(q.ss.band_width_select);
		// Consecutive over-limit window counter
		if (!en) begin
			d.cnt_q = 4'h0;
		end else if (tick) begin
			if (q.ss.over) begin
				d.cnt_q = hit ? req : cnt_inc;
			end else begin
				d.cnt_q = 4'h0;
			end
		end
		// Alert state machine
		case (q.fsm)
			ST_IDLE: begin
				if (en && tick && q.ss.over && hit) begin
					d.fsm = ST_ALERT;
					ev[EV_RAISE] = 1'b1;
				end
			end
			ST_ALERT: begin
				// Latched mode holds; low select releases on a below window
				if (!en || (tick && !q.ss.over && !q.ss.latch)) begin
					d.fsm = ST_IDLE;
					ev[EV_FALL] = 1'b1;
				end
			end
			default: begin
				d.fsm = ST_IDLE;
			end
		endcase
		// Write channel: address and data in either order
		if (AWVALID && AWREADY) begin
			d.aw_got = 1'b1;
			d.awaddr = AWADDR;
		end
		if (WVALID && WREADY) begin
			d.w_got = 1'b1;
			d.wdata = WDATA;
			d.wstrb0 = WSTRB[0];
		end
		if (q.aw_got && q.w_got) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			if (q.awaddr == REG_CTRL) begin
				if (q.wstrb0) begin
					d.sw_en_q = q.wdata[0];
				end
			end else if (q.awaddr == REG_STATUS) begin
				d.bresp = RESP_OKAY;
			end else if (q.awaddr == REG_INT_STAT) begin
				if (q.wstrb0) begin
					clr = q.wdata[1:0];
				end
			end else if (q.awaddr == REG_INT_MASK) begin
				if (q.wstrb0) begin
					d.imsk_q = q.wdata[1:0];
				end
			end else begin
				d.bresp = RESP_SLVERR;
			end
		end else if (q.bvalid && BREADY) begin
			d.bvalid = 1'b0;
		end
		// Sticky events, a new event beats the clear
		d.ist_q = (q.ist_q & ~clr) | ev;
		// Read channel
		if (ARVALID && ARREADY) begin
			d.rvalid = 1'b1;
			d.rresp = RESP_OKAY;
			d.rdata = 32'h0;
			if (ARADDR == REG_CTRL) begin
				d.rdata[0] = q.sw_en_q;
			end else if (ARADDR == REG_STATUS) begin
				d.rdata[15:0] = {q.cnt_q, q.band_q, q.ss.band_width_select, q.ss.dly,
					q.ss.latch, q.ss.over, en, alert};
			end else if (ARADDR == REG_INT_STAT) begin
				d.rdata[1:0] = q.ist_q;
			end else if (ARADDR == REG_INT_MASK) begin
				d.rdata[1:0] = q.imsk_q;
			end else begin
				d.rresp = RESP_SLVERR;
			end
		end else if (q.rvalid && RREADY) begin
			d.rvalid = 1'b0;
		end
	end

	// State register, released alert after reset
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			q <= '0;
			q.fsm <= ST_IDLE;
			q.sw_en_q <= CTRL_EN_RST;
		end else begin
			q <= d;
		end
	end

	// Checks
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RESET);

	property p_win;
		tick |-> ##100 tick;
	endproperty
	a_win: assert property (p_win) else $error("window period wrong");

	property p_eval;
		(q.cnt_q != $past(q.cnt_q)) |-> ($past(tick) || !$past(en));
	endproperty
	a_eval: assert property (p_eval) else $error("count moved off window end");

	property p_below;
		en && tick && !q.ss.over |=> q.cnt_q == 4'h0;
	endproperty
	a_below: assert property (p_below) else $error("below window kept count");

	property p_dis;
		!en |=> (q.cnt_q == 4'h0) && ALERT_N;
	endproperty
	a_dis: assert property (p_dis) else $error("disable did not clear");

	property p_qual;
		$rose(alert) |-> ($past(q.cnt_q) + 4'h1) >= qual_need($past(q.ss.dly));
	endproperty
	a_qual: assert property (p_qual) else $error("alert before enough windows");

	property p_fast;
		en && tick && q.ss.over && (q.ss.dly == PIN_FLOAT) |=> !ALERT_N;
	endproperty
	a_fast: assert property (p_fast) else $error("fast setting missed alert");

	property p_trans;
		alert && en && tick && !q.ss.over && !q.ss.latch |=> ALERT_N;
	endproperty
	a_trans: assert property (p_trans) else $error("transparent release missed");

	property p_latch;
		alert && en && q.ss.latch |=> !ALERT_N;
	endproperty
	a_latch: assert property (p_latch) else $error("latched alert released");

	property p_hold;
		alert && en && !(tick && !q.ss.over) |=> !ALERT_N;
	endproperty
	a_hold: assert property (p_hold) else $error("released while over limit");

	property p_band;
		q.ss.band_width_select == PIN_SUPPLY |=> BAND_WIDTH_SELECT == BAND_SUPPLY_MV;
	endproperty
	a_band: assert property (p_band) else $error("band decode wrong");

	property p_span;
		q.win_q <= WIN_LAST;
	endproperty
	a_span: assert property (p_span) else $error("window counter out of range");

	property p_only_end;
		$rose(alert) |-> $past(tick) && $past(q.ss.over) && $past(en);
	endproperty
	a_only_end: assert property (p_only_end) else $error("alert off window end");

	property p_mid;
		en && tick && q.ss.over && (q.ss.dly == PIN_GND) && (q.cnt_q + 4'h1 == QUAL_MID)
			|=> !ALERT_N;
	endproperty
	a_mid: assert property (p_mid) else $error("mid setting missed alert");

	property p_slow;
		en && tick && q.ss.over && (q.ss.dly == PIN_SUPPLY) && (q.cnt_q + 4'h1 == QUAL_SLOW)
			|=> !ALERT_N;
	endproperty
	a_slow: assert property (p_slow) else $error("long setting missed alert");

	property p_sat;
		q.cnt_q <= QUAL_SLOW;
	endproperty
	a_sat: assert property (p_sat) else $error("window count overran");

	property p_early;
		en && tick && q.ss.over && !alert && (q.cnt_q + 4'h1 < qual_need(q.ss.dly))
			|=> ALERT_N;
	endproperty
	a_early: assert property (p_early) else $error("alert too early");

	property p_step;
		en && tick && q.ss.over && (q.cnt_q + 4'h1 < qual_need(q.ss.dly))
			|=> q.cnt_q == $past(q.cnt_q) + 4'h1;
	endproperty
	a_step: assert property (p_step) else $error("over window not counted");

	property p_band_gnd;
		q.ss.band_width_select == PIN_GND |=> BAND_WIDTH_SELECT == BAND_GND_MV;
	endproperty
	a_band_gnd: assert property (p_band_gnd) else $error("band ground decode wrong");

	property p_band_flt;
		q.ss.band_width_select == PIN_FLOAT |=> BAND_WIDTH_SELECT == BAND_FLOAT_MV;
	endproperty
	a_band_flt: assert property (p_band_flt) else $error("band float decode wrong");

	property p_over_keep;
		alert && en && tick && q.ss.over |=> !ALERT_N;
	endproperty
	a_over_keep: assert property (p_over_keep) else $error("released while over");

	c_fast: cover property ($rose(alert) && q.ss.dly == PIN_FLOAT);
	c_mid: cover property ($rose(alert) && q.ss.dly == PIN_GND);
	c_slow: cover property ($rose(alert) && q.ss.dly == PIN_SUPPLY);
	c_held: cover property (alert && q.ss.latch && tick && !q.ss.over);
	c_wr: cover property (BVALID && BREADY);
endmodule

// File: verif/oaq_ctl_model.sv
// Controller model: drives the hold select pin of the alert qualifier.
// Assumes the bench asks for a latch clear with a one-cycle pulse.
`timescale 1ns/100ps
module oaq_ctl_model #(
	parameter int HOLD_CYC = 200
) (
	// Clock
	input wire logic clk,
	// Bench commands
	input wire logic latch_mode,
	input wire logic clr,
	// Hold select pin
	output logic latch
);
	int cnt = 0;
	// Clear holds the pin low for 20 us
	always @(posedge clk) begin
		if (clr) begin
			cnt <= HOLD_CYC;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
	// Back to latched mode once the hold ends
	assign latch = latch_mode && (cnt == 0);
endmodule

// File: verif/oaq_top_tb.sv
// Bench of the alert qualifier: pin scenarios and register accesses.
// Assumes the controller model drives the hold select pin.
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module oaq_top_tb
	import oaq_pkg::*;
;
	logic clk, rst, en, lat_mode, clr, over, latch_w, alert_n, irq;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0] dly, band_width_select, bresp, rresp, resp;
	logic [3:0] band, awaddr, araddr;
	logic [31:0] wdata, rdata, rd_q;
	logic [3:0] bw[4] = '{BAND_FLOAT_MV, BAND_GND_MV, BAND_SUPPLY_MV, BAND_FLOAT_MV};
	int nd[3] = '{QUAL_FAST, QUAL_MID, QUAL_SLOW};
	int n_errors = 0;
	int n_tests = 0;
	int n;

	oaq_top oaq_top_inst (.CORE_CLK(clk), .RESET(rst),
		.PINS(oaq_pin_t'({en, latch_w, over, dly, band_width_select})), .ALERT_N(alert_n),
		.BAND_WIDTH_SELECT(band), .IRQ(irq), .AWADDR(awaddr), .AWVALID(awvalid),
		.AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
		.ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
		.RVALID(rvalid), .RREADY(rready));
	oaq_ctl_model oaq_ctl_model_inst (.clk(clk), .latch_mode(lat_mode), .clr(clr),
		.latch(latch_w));

	task automatic wt(input int c);
		repeat (c) @(posedge clk);
	endtask
	// Count edges until the alert pin shows a level
	task automatic wait_al(input logic v, output int c);
		c = 0;
		while (alert_n !== v && c < 2000) begin
			@(posedge clk);
			c++;
		end
	endtask
	// AXI4-Lite write with expected response
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		`CHK(bresp, e)
	endtask
	// AXI4-Lite read
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask
	task automatic pulse_clr();
		clr <= 1'b1;
		wt(1);
		clr <= 1'b0;
	endtask
	task automatic end_of_test();
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Watchdog
	initial begin
		wt(40000);
		n_errors++;
		end_of_test();
	end
	// Scenarios
	initial begin
		{rst, en, lat_mode, clr, over, dly, band_width_select} = 9'h180;
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		wt(6);
		rst <= 1'b0;
		wt(5);
		`CHK(alert_n, 1'b1)
		`CHK(irq, 1'b0)
		for (int k = 0; k < 4; k++) begin
			band_width_select <= k[1:0];
			wt(6);
			`CHK(band, bw[k])
		end
		// Response delay per code, then transparent release
		for (int k = 0; k < 3; k++) begin
			dly <= k[1:0];
			wt(5);
			over <= 1'b1;
			wait_al(1'b0, n);
			`CHK(n >= 100 * (nd[k] - 1) && n <= 100 * nd[k] + 5, 1'b1)
			`CHK(alert_n, 1'b0)
			over <= 1'b0;
			wait_al(1'b1, n);
			`CHK(n <= 205, 1'b1)
		end
		// Events, mask and clear
		rd(REG_INT_STAT, rd_q, resp);
		`CHK(rd_q, 32'h3)
		`CHK(irq, 1'b0)
		wr(REG_INT_MASK, 32'h1, RESP_OKAY);
		wt(2);
		`CHK(irq, 1'b1)
		wr(REG_INT_STAT, 32'h1, RESP_OKAY);
		rd(REG_INT_STAT, rd_q, resp);
		`CHK(rd_q, 32'h2)
		`CHK(irq, 1'b0)
		rd(4'h2, rd_q, resp);
		`CHK(resp, RESP_SLVERR)
		wr(4'h2, 32'h0, RESP_SLVERR);
		wr(REG_STATUS, 32'hffff, RESP_OKAY);
		rd(REG_STATUS, rd_q, resp);
		`CHK(rd_q, 32'h2e2)
		`CHK(resp, RESP_OKAY)
		rd(REG_CTRL, rd_q, resp);
		`CHK(rd_q, 32'h1)
		// Latched mode and clear
		dly <= PIN_FLOAT;
		lat_mode <= 1'b1;
		over <= 1'b1;
		wait_al(1'b0, n);
		over <= 1'b0;
		wt(300);
		`CHK(alert_n, 1'b0)
		over <= 1'b1;
		pulse_clr();
		wt(150);
		`CHK(alert_n, 1'b0)
		wt(60);
		over <= 1'b0;
		wt(250);
		`CHK(alert_n, 1'b0)
		pulse_clr();
		wt(205);
		`CHK(alert_n, 1'b1)
		// Broken runs: below window, pin disable, soft disable
		lat_mode <= 1'b0;
		dly <= PIN_GND;
		for (int k = 0; k < 3; k++) begin
			over <= 1'b1;
			wt(350);
			if (k == 0) over <= 1'b0;
			if (k == 1) en <= 1'b0;
			if (k == 2) wr(REG_CTRL, 32'h0, RESP_OKAY);
			wt(150);
			over <= 1'b1;
			en <= 1'b1;
			if (k == 2) wr(REG_CTRL, 32'h1, RESP_OKAY);
			wt(350);
			`CHK(alert_n, 1'b1)
			over <= 1'b0;
			wt(250);
		end
		end_of_test();
	end
endmodule
